// file: verilog/and_bit_exec.sv
// execute core for the and and bit-modify words, with an axi4-lite register port
//
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module and_bit_exec
    import conjoin_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic [7:0] acc_out,
    output logic result_null_flag_out
);
    exec_if dec_bus ();

    instr_decode u_decode (
        .dec(dec_bus.decoder)
    );

    // write channel holding registers
    logic aw_held_q, aw_held_d;
    logic [ADDR_W-1:0] awaddr_q, awaddr_d;
    logic w_held_q, w_held_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic wr_do;
    logic wr_hit;

    // read channel
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;

    // core state
    logic [7:0] acc_q, acc_d;
    logic null_flag_q, null_flag_d;
    logic unrec_q, unrec_d;
    logic [4:0] index_q, index_d;
    logic [11:0] last_instr_q, last_instr_d;
    logic [31:0][7:0] file_q, file_d;
    logic exec;
    logic [7:0] and_operand;
    logic [7:0] and_res;

    // a new write is refused until its response has been taken
    assign s_axi_awready_out = !aw_held_q && !bvalid_q;
    assign s_axi_wready_out = !w_held_q && !bvalid_q;
    assign s_axi_bvalid_out = bvalid_q;
    assign s_axi_bresp_out = bresp_q;
    assign s_axi_arready_out = !rvalid_q;
    assign s_axi_rvalid_out = rvalid_q;
    assign s_axi_rdata_out = rdata_q;
    assign s_axi_rresp_out = rresp_q;
    assign acc_out = acc_q;
    assign result_null_flag_out = null_flag_q;

    assign wr_do = aw_held_q && w_held_q;
    assign wr_hit = awaddr_q == OFF_INSTR || awaddr_q == OFF_ACC || awaddr_q == OFF_STATUS
        || awaddr_q == OFF_FILE_INDEX || awaddr_q == OFF_FILE_DATA
        || awaddr_q == OFF_LAST_INSTR;

    always_comb begin
        aw_held_d = aw_held_q;
        awaddr_d = awaddr_q;
        w_held_d = w_held_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_held_d = 1'b1;
            awaddr_d = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_held_d = 1'b1;
            wdata_d = s_axi_wdata_in;
            wstrb_d = s_axi_wstrb_in;
        end
        if (wr_do) begin
            aw_held_d = 1'b0;
            w_held_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        if (bvalid_q && s_axi_bready_in) begin
            bvalid_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            aw_held_q <= 1'b0;
            awaddr_q <= '0;
            w_held_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else begin
            aw_held_q <= aw_held_d;
            awaddr_q <= awaddr_d;
            w_held_q <= w_held_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
        end
    end

    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (s_axi_arvalid_in && s_axi_arready_out) begin
            rvalid_d = 1'b1;
            rresp_d = RESP_OKAY;
            rdata_d = '0;
            unique case (s_axi_araddr_in)
                OFF_INSTR: rdata_d = '0;
                OFF_ACC: rdata_d = {24'h000000, acc_q};
                OFF_STATUS: rdata_d = {30'h0, unrec_q, null_flag_q};
                OFF_FILE_INDEX: rdata_d = {27'h0, index_q};
                OFF_FILE_DATA: rdata_d = {24'h000000, file_q[index_q]};
                OFF_LAST_INSTR: rdata_d = {20'h00000, last_instr_q};
                default: rresp_d = RESP_SLVERR;
            endcase
        end else if (rvalid_q && s_axi_rready_in) begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else begin
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    // a word executes only when both low byte lanes carry it, so a torn word never runs
    assign dec_bus.word = wdata_q[11:0];
    assign exec = wr_do && awaddr_q == OFF_INSTR && wstrb_q[0] && wstrb_q[1];
    assign and_operand = (dec_bus.op == OP_CONJOIN_ACC_IMMEDIATE) ? dec_bus.imm
        : file_q[dec_bus.reg_index];
    assign and_res = acc_q & and_operand;

    always_comb begin
        acc_d = acc_q;
        null_flag_d = null_flag_q;
        unrec_d = unrec_q;
        index_d = index_q;
        last_instr_d = last_instr_q;
        file_d = file_q;
        if (wr_do && wstrb_q[0]) begin
            if (awaddr_q == OFF_ACC) begin
                acc_d = wdata_q[7:0];
            end
            if (awaddr_q == OFF_STATUS) begin
                null_flag_d = wdata_q[STATUS_NULL_BIT];
                if (wdata_q[STATUS_UNREC_BIT]) begin
                    unrec_d = 1'b0;
                end
            end
            if (awaddr_q == OFF_FILE_INDEX) begin
                index_d = wdata_q[4:0];
            end
            if (awaddr_q == OFF_FILE_DATA) begin
                file_d[index_q] = wdata_q[7:0];
            end
        end
        if (exec) begin
            last_instr_d = dec_bus.word;
            unique case (dec_bus.op)
                OP_CONJOIN_ACC_REG: begin
                    null_flag_d = (and_res == 8'h00);
                    if (dec_bus.dest_file) begin
                        file_d[dec_bus.reg_index] = and_res;
                    end else begin
                        acc_d = and_res;
                    end
                end
                OP_CONJOIN_ACC_IMMEDIATE: begin
                    acc_d = and_res;
                    null_flag_d = (and_res == 8'h00);
                end
                OP_CLEAR_REG_BIT: begin
                    file_d[dec_bus.reg_index][dec_bus.bit_pos] = 1'b0;
                end
                OP_SET_REG_BIT: begin
                    file_d[dec_bus.reg_index][dec_bus.bit_pos] = 1'b1;
                end
                OP_NONE: begin
                    unrec_d = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            acc_q <= ACC_RST;
            null_flag_q <= NULL_FLAG_RST;
            unrec_q <= 1'b0;
            index_q <= INDEX_RST;
            last_instr_q <= LAST_INSTR_RST;
            file_q <= {32{FILE_RST}};
        end else begin
            acc_q <= acc_d;
            null_flag_q <= null_flag_d;
            unrec_q <= unrec_d;
            index_q <= index_d;
            last_instr_q <= last_instr_d;
            file_q <= file_d;
        end
    end

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);

    a_and_reg_acc: assert property (
        exec && dec_bus.op == OP_CONJOIN_ACC_REG && !dec_bus.dest_file
        |=> acc_q == $past(and_res) && $stable(file_q))
        else $error("register and to accumulator gave wrong result");

    a_and_reg_dest_acc: assert property (
        exec && wdata_q[11:5] == {OPC6_CONJOIN_ACC_REG, 1'b0}
        |=> acc_q == ($past(acc_q) & $past(and_operand)))
        else $error("destination zero did not load accumulator");

    a_and_reg_dest_file: assert property (
        exec && dec_bus.op == OP_CONJOIN_ACC_REG && dec_bus.dest_file
        |=> file_q[$past(dec_bus.reg_index)] == $past(and_res) && $stable(acc_q))
        else $error("destination one did not write file register");

    a_and_imm_acc: assert property (
        exec && wdata_q[11:8] == OPC4_CONJOIN_ACC_IMMEDIATE
        |=> acc_q == ($past(acc_q) & $past(wdata_q[7:0])))
        else $error("immediate and result wrong");

    a_and_imm_no_file: assert property (
        exec && dec_bus.op == OP_CONJOIN_ACC_IMMEDIATE |=> $stable(file_q))
        else $error("immediate and touched the register file");

    a_bit_clear_only: assert property (
        exec && dec_bus.op == OP_CLEAR_REG_BIT
        |=> file_q[$past(dec_bus.reg_index)][$past(dec_bus.bit_pos)] == 1'b0
            && $stable(null_flag_q) && $stable(acc_q))
        else $error("bit clear failed or disturbed state");

    a_bit_set_only: assert property (
        exec && dec_bus.op == OP_SET_REG_BIT
        |=> file_q[$past(dec_bus.reg_index)][$past(dec_bus.bit_pos)] == 1'b1
            && $stable(null_flag_q) && $stable(acc_q))
        else $error("bit set failed or disturbed state");

    a_null_flag_and: assert property (
        exec && (dec_bus.op == OP_CONJOIN_ACC_REG || dec_bus.op == OP_CONJOIN_ACC_IMMEDIATE)
        |=> null_flag_q == ($past(and_res) == 8'h00))
        else $error("zero flag wrong after and");

    a_bresp_follows: assert property (
        wr_do |=> s_axi_bvalid_out)
        else $error("write response missing");

    a_bresp_holds: assert property (
        s_axi_bvalid_out && !s_axi_bready_in
        |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
        else $error("write response dropped before it was taken");

    c_and_reg_file: cover property (exec && dec_bus.op == OP_CONJOIN_ACC_REG && dec_bus.dest_file);
    c_and_imm_zero: cover property (exec && dec_bus.op == OP_CONJOIN_ACC_IMMEDIATE
        && and_res == 8'h00);
    c_bit_set: cover property (exec && dec_bus.op == OP_SET_REG_BIT);
    c_bit_clear: cover property (exec && dec_bus.op == OP_CLEAR_REG_BIT);
endmodule
`default_nettype wire

// file: shared/conjoin_pkg.sv
// constants and types shared by the and / bit-modify execute block
package conjoin_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_INSTR = 8'h00;
    localparam logic [7:0] OFF_ACC = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_FILE_INDEX = 8'h0c;
    localparam logic [7:0] OFF_FILE_DATA = 8'h10;
    localparam logic [7:0] OFF_LAST_INSTR = 8'h14;
    localparam int STATUS_NULL_BIT = 0;
    localparam int STATUS_UNREC_BIT = 1;
    localparam logic [5:0] OPC6_CONJOIN_ACC_REG = 6'h05;
    localparam logic [3:0] OPC4_CONJOIN_ACC_IMMEDIATE = 4'he;
    localparam logic [3:0] OPC4_CLEAR_REG_BIT = 4'h4;
    localparam logic [3:0] OPC4_SET_REG_BIT = 4'h5;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic NULL_FLAG_RST = 1'b0;
    localparam logic [7:0] FILE_RST = 8'h00;
    localparam logic [4:0] INDEX_RST = 5'h00;
    localparam logic [11:0] LAST_INSTR_RST = 12'h000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        OP_NONE,
        OP_CONJOIN_ACC_REG,
        OP_CONJOIN_ACC_IMMEDIATE,
        OP_CLEAR_REG_BIT,
        OP_SET_REG_BIT
    } op_type;
endpackage

// file: shared/exec_if.sv
// carrier between the execute core and the instruction decoder
`timescale 1ns/1ps
`default_nettype none
interface exec_if;
    import conjoin_pkg::*;
    logic [11:0] word;
    op_type op;
    logic [4:0] reg_index;
    logic [2:0] bit_pos;
    logic dest_file;
    logic [7:0] imm;
    modport core (output word, input op, reg_index, bit_pos, dest_file, imm);
    modport decoder (input word, output op, reg_index, bit_pos, dest_file, imm);
endinterface
`default_nettype wire

// file: verilog/instr_decode.sv
// splits a 12-bit instruction word into operation and operand fields
`timescale 1ns/1ps
`default_nettype none
module instr_decode
    import conjoin_pkg::*;
(
    exec_if.decoder dec
);
    always_comb begin
        dec.reg_index = dec.word[4:0];
        dec.bit_pos = dec.word[7:5];
        dec.dest_file = dec.word[5];
        dec.imm = dec.word[7:0];
        if (dec.word[11:6] == OPC6_CONJOIN_ACC_REG) begin
            dec.op = OP_CONJOIN_ACC_REG;
        end else if (dec.word[11:8] == OPC4_CONJOIN_ACC_IMMEDIATE) begin
            dec.op = OP_CONJOIN_ACC_IMMEDIATE;
        end else if (dec.word[11:8] == OPC4_CLEAR_REG_BIT) begin
            dec.op = OP_CLEAR_REG_BIT;
        end else if (dec.word[11:8] == OPC4_SET_REG_BIT) begin
            dec.op = OP_SET_REG_BIT;
        end else begin
            dec.op = OP_NONE;
        end
    end
endmodule
`default_nettype wire

// file: test/prog_mem_model.sv
// program memory model that serves the instruction words the bench executes
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model (
    input wire logic [2:0] pc_in,
    output logic [11:0] word_out
);
    // fixed program; the bench supplies each word through the instruction register
    always_comb begin
        case (pc_in)
            3'h0: word_out = 12'h163;
            3'h1: word_out = 12'h143;
            3'h2: word_out = 12'he5f;
            3'h3: word_out = 12'he00;
            3'h4: word_out = 12'h4e3;
            3'h5: word_out = 12'h5e3;
            3'h6: word_out = 12'h51f;
            default: word_out = 12'h163;
        endcase
    end
endmodule
`default_nettype wire

// file: test/tb_and_and_bit_modify_exec.sv
// self-checking bench for the and / bit-modify execute block
`timescale 1ns/1ps
`default_nettype none
module tb_and_and_bit_modify_exec;
    import conjoin_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, null_flag;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd;
    logic [7:0] acc;
    logic [2:0] pc = 3'h0;
    logic [11:0] pm_word;
    int n_fail = 0;
    int comparisons = 0;

    always #2.5 clk = ~clk;

    and_bit_exec i_dut (.core_clk_in(clk), .rst_in(rst), .s_axi_awaddr_in(awaddr),
        .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
        .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready), .acc_out(acc), .result_null_flag_out(null_flag));
    prog_mem_model i_prog (.pc_in(pc), .word_out(pm_word));

    task automatic stop_test;
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // readies are sampled at the falling edge: inputs only move after rising edges
    // only the watchdog ends a wait: the tasks assume no answer time
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        logic pa, pw, pb, hs_a, hs_w, hs_b;
        pa = 1'b1;
        pw = 1'b1;
        pb = 1'b1;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (pb) begin
            @(negedge clk);
            hs_a = pa && awready === 1'b1;
            hs_w = pw && wready === 1'b1;
            hs_b = bvalid === 1'b1;
            if (hs_b) begin
                resp = bresp;
            end
            @(posedge clk);
            if (hs_a) begin
                pa = 1'b0;
                awvalid <= 1'b0;
            end
            if (hs_w) begin
                pw = 1'b0;
                wvalid <= 1'b0;
            end
            if (hs_b) begin
                pb = 1'b0;
                bready <= 1'b0;
            end
        end
    endtask

    task automatic axi_read(input logic [7:0] a);
        logic pa, pr, hs_a, hs_r;
        pa = 1'b1;
        pr = 1'b1;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (pr) begin
            @(negedge clk);
            hs_a = pa && arready === 1'b1;
            hs_r = rvalid === 1'b1;
            if (hs_r) begin
                rd = rdata;
                resp = rresp;
            end
            @(posedge clk);
            if (hs_a) begin
                pa = 1'b0;
                arvalid <= 1'b0;
            end
            if (hs_r) begin
                pr = 1'b0;
                rready <= 1'b0;
            end
        end
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        axi_read(a);
        check(what, rd, exp);
        check("rresp", {30'h0, resp}, {30'h0, RESP_OKAY});
    endtask

    // fetch a word from program memory and execute it
    task automatic exec_word(input logic [2:0] p);
        @(posedge clk);
        pc <= p;
        @(negedge clk);
        axi_write(OFF_INSTR, {20'h0, pm_word});
        check("instr bresp", {30'h0, resp}, {30'h0, RESP_OKAY});
    endtask

    initial begin
        #100000;
        n_fail++;
        stop_test();
    end

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd_chk("acc reset", OFF_ACC, {24'h0, ACC_RST});
        rd_chk("status reset", OFF_STATUS, 32'h0);
        rd_chk("last reset", OFF_LAST_INSTR, {20'h0, LAST_INSTR_RST});
        axi_write(OFF_FILE_INDEX, 32'h3);
        axi_write(OFF_FILE_DATA, 32'hc2);
        axi_write(OFF_ACC, 32'h17);
        exec_word(3'h0);
        rd_chk("file after reg and d1", OFF_FILE_DATA, 32'h02);
        rd_chk("acc after reg and d1", OFF_ACC, 32'h17);
        rd_chk("status after reg and d1", OFF_STATUS, 32'h0);
        exec_word(3'h1);
        rd_chk("acc after reg and d0", OFF_ACC, 32'h02);
        rd_chk("file after reg and d0", OFF_FILE_DATA, 32'h02);
        axi_write(OFF_ACC, 32'ha3);
        exec_word(3'h2);
        rd_chk("acc after imm and", OFF_ACC, 32'h03);
        check("acc port", {24'h0, acc}, 32'h03);
        rd_chk("file after imm and", OFF_FILE_DATA, 32'h02);
        exec_word(3'h3);
        rd_chk("acc after imm and zero", OFF_ACC, 32'h0);
        rd_chk("status zero set", OFF_STATUS, 32'h1);
        check("null flag port", {31'h0, null_flag}, 32'h1);
        axi_write(OFF_FILE_DATA, 32'hc7);
        exec_word(3'h4);
        rd_chk("file after clear bit7", OFF_FILE_DATA, 32'h47);
        rd_chk("status kept by clear", OFF_STATUS, 32'h1);
        axi_write(OFF_FILE_DATA, 32'h0a);
        exec_word(3'h5);
        rd_chk("file after set bit7", OFF_FILE_DATA, 32'h8a);
        rd_chk("last word", OFF_LAST_INSTR, 32'h5e3);
        // top register index and bit zero are the field boundaries
        axi_write(OFF_FILE_INDEX, 32'h1f);
        axi_write(OFF_FILE_DATA, 32'h00);
        exec_word(3'h6);
        rd_chk("file31 after set bit0", OFF_FILE_DATA, 32'h01);
        rd_chk("status kept by set", OFF_STATUS, 32'h1);
        axi_write(OFF_FILE_INDEX, 32'h3);
        axi_write(OFF_ACC, 32'hff);
        exec_word(3'h7);
        rd_chk("file after and ff", OFF_FILE_DATA, 32'h8a);
        rd_chk("status zero cleared", OFF_STATUS, 32'h0);
        check("null flag port clear", {31'h0, null_flag}, 32'h0);
        // a word missing its second byte lane must not run
        wstrb <= 4'h1;
        axi_write(OFF_INSTR, 32'he00);
        wstrb <= 4'hf;
        check("torn instr bresp", {30'h0, resp}, {30'h0, RESP_OKAY});
        rd_chk("acc kept by torn word", OFF_ACC, 32'hff);
        rd_chk("last kept by torn word", OFF_LAST_INSTR, 32'h163);
        // a word outside the four operations raises the sticky bit and is kept as the last word
        axi_write(OFF_INSTR, 32'h000);
        rd_chk("status unknown word", OFF_STATUS, 32'h2);
        rd_chk("acc kept by unknown word", OFF_ACC, 32'hff);
        rd_chk("last unknown word", OFF_LAST_INSTR, 32'h000);
        axi_write(OFF_STATUS, 32'h2);
        rd_chk("status sticky cleared", OFF_STATUS, 32'h0);
        // reset in mid-run puts the accumulator and file back
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check("acc port after reset", {24'h0, acc}, {24'h0, ACC_RST});
        check("null flag after reset", {31'h0, null_flag}, {31'h0, NULL_FLAG_RST});
        rd_chk("file after reset", OFF_FILE_DATA, {24'h0, FILE_RST});
        axi_write(8'h18, 32'h55);
        check("unmapped bresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
        axi_read(8'h18);
        check("unmapped rresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
        check("unmapped rdata", rd, 32'h0);
        stop_test();
    end
endmodule
`default_nettype wire
